/* verif/hsp_chk.sv */
// Port checker for the host pin block
`timescale 1ns/1ps
module hsp_chk (
  // Clock, reset and power state
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_stop,
  // Register bus handshakes
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic i_rready,
  // Decoded strobes and pin enables
  input wire logic o_data_strobe,
  input wire logic o_write_strobe,
  input wire logic o_read_strobe,
  input wire logic o_host_ack,
  input wire logic [3:0] o_pin_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_dw; !(o_data_strobe && o_write_strobe); endproperty
  a_dw: assert property (p_dw) else $error("ds/wr");
  property p_dr; !(o_data_strobe && o_read_strobe); endproperty
  a_dr: assert property (p_dr) else $error("ds/rd");
  property p_so; i_stop |=> o_pin_oe == 4'h0; endproperty
  a_so: assert property (p_so) else $error("stop oe");
  property p_si; i_stop [*2] |=> !(o_data_strobe || o_host_ack); endproperty
  a_si: assert property (p_si) else $error("stop in");
  property p_wl;
    i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid;
  endproperty
  a_wl: assert property (p_wl) else $error("b late");
  property p_bo; o_bvalid && i_bready |=> !o_bvalid; endproperty
  a_bo: assert property (p_bo) else $error("b twice");
  property p_rl; i_arvalid && o_arready |=> o_rvalid; endproperty
  a_rl: assert property (p_rl) else $error("r late");
  property p_ro; o_rvalid && i_rready |=> !o_rvalid; endproperty
  a_ro: assert property (p_ro) else $error("r twice");
endmodule
bind hsp_host_pins hsp_chk u_chk (
  .i_clk(i_clk),
  .i_rst_n(i_rst_n),
  .i_stop(i_stop),
  .i_awvalid(i_awvalid),
  .o_awready(o_awready),
  .i_wvalid(i_wvalid),
  .o_wready(o_wready),
  .o_bvalid(o_bvalid),
  .i_bready(i_bready),
  .i_arvalid(i_arvalid),
  .o_arready(o_arready),
  .o_rvalid(o_rvalid),
  .i_rready(i_rready),
  .o_data_strobe(o_data_strobe),
  .o_write_strobe(o_write_strobe),
  .o_read_strobe(o_read_strobe),
  .o_host_ack(o_host_ack),
  .o_pin_oe(o_pin_oe)
);

/* verif/hsp_host_model.sv */
// Host side model: strobe and ack drivers, pull-ups
`timescale 1ns/1ps
module hsp_host_model (
  // Device pin drive
  input wire logic [3:0] i_out,
  input wire logic [3:0] i_oe,
  // Host drive; lines not enabled fall to the pull-up
  input wire logic [3:0] i_drv,
  input wire logic [3:0] i_en,
  // Resolved pin levels
  output logic [3:0] o_wire
);
  // Released lines read high, never the last driven value
  assign o_wire = i_oe & i_out | ~i_oe & (~i_en | i_drv);
endmodule

/* verif/hsp_host_pins_tb.sv */
// Self-checking bench for the host pin block
`timescale 1ns/1ps
module hsp_host_pins_tb;
  import hsp_pkg::*;
  logic i_clk = 0, i_rst_n = 0, i_stop = 0, i_wait = 0, i_bready = 1;
  logic i_awvalid = 0, i_wvalid = 0, i_arvalid = 0, i_rready = 1;
  logic i_host_req = 0, i_tx_req = 0, i_rx_req = 0, o_awready, o_wready;
  logic o_bvalid, o_arready, o_rvalid, o_data_strobe, o_write_strobe;
  logic o_read_strobe, o_host_ack;
  logic [1:0] o_bresp, o_rresp;
  logic [1:0] b_got, r_got;
  logic [3:0] drv = 0, den = 0, pin, o_pin, o_pin_oe, e;
  logic [7:0] i_awaddr = 0, i_araddr = 0, x8, obs;
  logic [10:0] c;
  logic [31:0] i_wdata = 0, o_rdata, got, rnd = 32'hccc62a4c;
  int n_mismatch = 0, samples_checked = 0, cyc = 0;
  hsp_host_pins u_dut (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_stop(i_stop),
    .i_wait(i_wait),
    .i_host_req(i_host_req),
    .i_tx_req(i_tx_req),
    .i_rx_req(i_rx_req),
    .i_pin(pin),
    .o_pin(o_pin),
    .o_pin_oe(o_pin_oe),
    .o_data_strobe(o_data_strobe),
    .o_write_strobe(o_write_strobe),
    .o_read_strobe(o_read_strobe),
    .o_host_ack(o_host_ack),
    .i_awaddr(i_awaddr),
    .i_awvalid(i_awvalid),
    .o_awready(o_awready),
    .i_wdata(i_wdata),
    .i_wstrb(4'hf),
    .i_wvalid(i_wvalid),
    .o_wready(o_wready),
    .o_bresp(o_bresp),
    .o_bvalid(o_bvalid),
    .i_bready(i_bready),
    .i_araddr(i_araddr),
    .i_arvalid(i_arvalid),
    .o_arready(o_arready),
    .o_rdata(o_rdata),
    .o_rresp(o_rresp),
    .o_rvalid(o_rvalid),
    .i_rready(i_rready)
  );
  hsp_host_model u_host (.i_out(o_pin), .i_oe(o_pin_oe), .i_drv(drv),
    .i_en(den), .o_wire(pin));
  assign obs = {o_pin_oe[3:2], pin[3:2], o_data_strobe, o_write_strobe,
    o_read_strobe, o_host_ack};
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      stop_test();
    end
  end
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // Open-drain high reads the same as driven high via pull-up
  function automatic logic [7:0] exp_host(logic [10:0] k, logic [3:0] p,
      logic [2:0] q, logic s);
    logic l2, l3;
    l2 = (k[2] ? q[1] : q[0]) == (k[2] ? k[8] : k[7]);
    l3 = k[2] ? q[2] == k[9] : p[3];
    if (s)
      return {2'h0, l3 | k[2], 5'h10};
    return {k[2] & !(k[3] & l3), !(k[3] & l2), l3, l2, !k[1] & p[0] == k[4],
      k[1] & p[0] == k[5], k[1] & p[1] == k[6], !k[2] & p[3] == k[10]};
  endfunction
  task automatic chk(logic [31:0] g, x);
    samples_checked++;
    if (g !== x) begin
      n_mismatch++;
      $display("wrong value %0t %h %h", $time, g, x);
    end
  endtask
  task automatic chk_resp(logic [1:0] g, x);
    samples_checked++;
    if (g !== x) begin
      n_mismatch++;
      $display("wrong value %0t %h %h", $time, g, x);
    end
  endtask
  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1;
    i_wvalid <= 1;
    do begin
      @(posedge i_clk);
      if (o_awready)
        i_awvalid <= 0;
      if (o_wready)
        i_wvalid <= 0;
    end while (!o_bvalid);
    b_got = o_bresp;
  endtask
  task automatic rd_reg(logic [7:0] a);
    @(posedge i_clk);
    i_araddr <= a;
    i_arvalid <= 1;
    do begin
      @(posedge i_clk);
      if (o_arready)
        i_arvalid <= 0;
    end while (!o_rvalid);
    got = o_rdata;
    r_got = o_rresp;
  endtask
  task automatic stop_test();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1;
    rd_reg(HSP_CTRL_OFS);
    chk(got, 32'h0);
    chk_resp(r_got, HSP_RESP_OKAY);
    // Software request alone must pull the active-low request pin
    wr_reg(HSP_REQ_OFS, 32'h7);
    chk_resp(b_got, HSP_RESP_OKAY);
    rd_reg(HSP_REQ_OFS);
    chk(got, 32'h7);
    chk({o_pin_oe[2], o_pin[2]}, 32'h2);
    wr_reg(HSP_REQ_OFS, 32'h0);
    // Unmapped word answers with an error and reads as zero
    wr_reg(8'h18, 32'h1);
    chk_resp(b_got, HSP_RESP_SLVERR);
    rd_reg(8'h18);
    chk_resp(r_got, HSP_RESP_SLVERR);
    chk(got, 32'h0);
    for (int i = 0; i < 40; i++) begin
      rnd = xs(rnd);
      c = i ? rnd[10:0] & 11'h7fe : 11'h0;
      wr_reg(HSP_CTRL_OFS, {21'h0, c});
      chk_resp(b_got, HSP_RESP_OKAY);
      drv <= rnd[15:12];
      den <= {!c[2], 3'h3};
      {i_rx_req, i_tx_req, i_host_req} <= rnd[18:16];
      i_wait <= rnd[19];
      // One forced stop pass so the stop checks always see it
      i_stop <= rnd[22:20] == 3'h0 || i == 5;
      repeat (4) @(posedge i_clk);
      x8 = exp_host(c, drv, rnd[18:16], i_stop);
      chk(obs, x8);
    end
    i_stop <= 0;
    for (int i = 0; i < 10; i++) begin
      rnd = xs(rnd);
      wr_reg(HSP_CTRL_OFS, 32'h1);
      wr_reg(HSP_DIR_OFS, {28'h0, rnd[3:0]});
      wr_reg(HSP_DOUT_OFS, {28'h0, rnd[7:4]});
      drv <= rnd[11:8];
      den <= ~rnd[3:0];
      e = rnd[3:0] & rnd[7:4] | ~rnd[3:0] & rnd[11:8];
      rd_reg(HSP_PIN_OFS);
      chk_resp(r_got, HSP_RESP_OKAY);
      chk({o_pin_oe, pin, got[3:0]}, {rnd[3:0], e, e});
    end
    stop_test();
  end
endmodule

/* verilog/hsp_host_pins.sv */
// Host strobe and request pin control with GPIO fallback and AXI4-Lite regs
`timescale 1ns/1ps
// Contract
// [R1] Single-strobe host mode: pin is data strobe, polarity bit, active-low reset.
// [R2] Double-strobe host mode: pin is write strobe, polarity bit, active-low reset.
// [R3] Single-request mode: combined request out, polarity, driven or open-drain.
// [R4] Double-request mode: transmit request out, polarity, driven or open-drain.
// [R5] Double-request mode: receive request out, polarity, driven or open-drain.
// [R6] Single-request mode: host acknowledge input, polarity, active-low reset.
// [R7] GPIO mode: each pin individually input or output by direction bit.
// [R8] Stop: keep configuration, ignore inputs, tri-state outputs.
// [R9] Wait state leaves every pin unchanged.
// [R10] Double-strobe host mode: companion pin is read strobe, polarity bit.
// [R11] Each polarity is an inverting bit, reset value selects active-low.
module hsp_host_pins
  import hsp_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Power states
  input wire logic i_stop,
  input wire logic i_wait,
  // Requests from the host interface core, active high
  input wire logic i_host_req,
  input wire logic i_tx_req,
  input wire logic i_rx_req,
  // Pins: [0] data/write strobe, [1] read strobe, [2] req/trq, [3] ack/rrq
  input wire logic [3:0] i_pin,
  output logic [3:0] o_pin,
  output logic [3:0] o_pin_oe,
  // Decoded strobes to the core, active high
  output logic o_data_strobe,
  output logic o_write_strobe,
  output logic o_read_strobe,
  output logic o_host_ack,
  // AXI4-Lite slave
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready
);
  logic [HSP_CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [3:0] dir_r, dir_nxt, dout_r, dout_nxt;
  logic [3:0] pin_r, pin_nxt, oe_r, oe_nxt, in_r, in_nxt;
  logic ds_r, ds_nxt, wr_r, wr_nxt, rd_r, rd_nxt, ack_r, ack_nxt;
  logic sw_req_r, sw_req_nxt;
  logic [1:0] sw_tr_r, sw_tr_nxt;
  logic aw_r, aw_nxt, w_r, w_nxt, b_r, b_nxt, ar_r, ar_nxt, r_r, r_nxt;
  logic aw_rdy_r, aw_rdy_nxt, w_rdy_r, w_rdy_nxt;
  logic [7:0] awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt, rd_data_r, rd_data_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic gpio, dstb, dreq, od, req_a, trq_a, rrq_a;
  logic [3:0] drv_val, drv_en, pin_in;

  // Pin logic
  always_comb begin
    gpio = ctrl_r[HSP_GPIO_BIT];
    dstb = ctrl_r[HSP_DSTROBE_BIT];
    dreq = ctrl_r[HSP_DREQ_BIT];
    od = ctrl_r[HSP_OD_BIT];
    // Internal request, inverted when polarity bit is clear [R11]
    req_a = (i_host_req | sw_req_r) ^ ~ctrl_r[HSP_POL_REQ_BIT]; // [R3]
    trq_a = (i_tx_req | sw_tr_r[0]) ^ ~ctrl_r[HSP_POL_TRQ_BIT]; // [R4]
    rrq_a = (i_rx_req | sw_tr_r[1]) ^ ~ctrl_r[HSP_POL_RRQ_BIT]; // [R5]
    drv_val = 4'h0;
    drv_en = 4'h0;
    if (gpio) begin
      drv_val = dout_r; // [R7]
      drv_en = dir_r; // [R7]
    end else begin
      // Open drain only pulls low; high level released
      drv_val[2] = dreq ? trq_a : req_a;
      drv_en[2] = ~od | ~drv_val[2]; // [R3] [R4]
      if (dreq) begin
        drv_val[3] = rrq_a;
        drv_en[3] = ~od | ~rrq_a; // [R5]
      end
    end
    // Stop keeps config but floats outputs and freezes inputs [R8]
    pin_nxt = i_stop ? pin_r : drv_val;
    oe_nxt = i_stop ? 4'h0 : drv_en; // [R8]
    in_nxt = i_stop ? in_r : i_pin; // [R8]
    pin_in = in_r;
    // Wait state input i_wait is not used here, so pins are unaffected [R9]
    ds_nxt = 1'b0;
    wr_nxt = 1'b0;
    rd_nxt = 1'b0;
    ack_nxt = 1'b0;
    if (!gpio && !i_stop) begin
      if (dstb) begin
        wr_nxt = pin_in[0] ^ ~ctrl_r[HSP_POL_WR_BIT]; // [R2] [R11]
        rd_nxt = pin_in[1] ^ ~ctrl_r[HSP_POL_RD_BIT]; // [R10] [R11]
      end else begin
        ds_nxt = pin_in[0] ^ ~ctrl_r[HSP_POL_DS_BIT]; // [R1] [R11]
      end
      if (!dreq) begin
        ack_nxt = pin_in[3] ^ ~ctrl_r[HSP_POL_ACK_BIT]; // [R6] [R11]
      end
    end
  end

  // AXI4-Lite slave: write takes address and data in either order
  always_comb begin
    ctrl_nxt = ctrl_r;
    dir_nxt = dir_r;
    dout_nxt = dout_r;
    sw_req_nxt = sw_req_r;
    sw_tr_nxt = sw_tr_r;
    aw_nxt = aw_r;
    w_nxt = w_r;
    awa_nxt = awa_r;
    wd_nxt = wd_r;
    b_nxt = b_r;
    bresp_nxt = bresp_r;
    r_nxt = r_r;
    rd_data_nxt = rd_data_r;
    rresp_nxt = rresp_r;
    // Ready rises a cycle after valid so it can leave a flop
    aw_rdy_nxt = i_awvalid && !aw_rdy_r && !aw_r && !b_r;
    w_rdy_nxt = i_wvalid && !w_rdy_r && !w_r && !b_r;
    ar_nxt = i_arvalid && !ar_r && !r_r;
    if (i_awvalid && aw_rdy_r) begin
      aw_nxt = 1'b1;
      awa_nxt = i_awaddr;
    end
    if (i_wvalid && w_rdy_r) begin
      w_nxt = 1'b1;
      wd_nxt = i_wdata;
    end
    if (aw_r && w_r) begin
      aw_nxt = 1'b0;
      w_nxt = 1'b0;
      b_nxt = 1'b1;
      bresp_nxt = HSP_RESP_OKAY;
      unique case ({awa_r[7:2], 2'b00})
        HSP_CTRL_OFS: ctrl_nxt = wd_r[HSP_CTRL_W-1:0];
        HSP_DIR_OFS: dir_nxt = wd_r[3:0];
        HSP_DOUT_OFS: dout_nxt = wd_r[3:0];
        HSP_REQ_OFS: begin
          sw_req_nxt = wd_r[0];
          sw_tr_nxt = wd_r[2:1];
        end
        HSP_PIN_OFS, HSP_STAT_OFS: ;
        default: bresp_nxt = HSP_RESP_SLVERR;
      endcase
    end
    if (b_r && i_bready) begin
      b_nxt = 1'b0;
    end
    // Read data only after the address handshake edge
    if (i_arvalid && ar_r) begin
      r_nxt = 1'b1;
      rresp_nxt = HSP_RESP_OKAY;
      rd_data_nxt = 32'h0000_0000;
      unique case ({i_araddr[7:2], 2'b00})
        HSP_CTRL_OFS: rd_data_nxt[HSP_CTRL_W-1:0] = ctrl_r;
        HSP_DIR_OFS: rd_data_nxt[3:0] = dir_r;
        HSP_DOUT_OFS: rd_data_nxt[3:0] = dout_r;
        HSP_PIN_OFS: rd_data_nxt[3:0] = in_r;
        HSP_REQ_OFS: rd_data_nxt[2:0] = {sw_tr_r, sw_req_r};
        HSP_STAT_OFS: rd_data_nxt[7:0] = {oe_r, ack_r, rd_r, wr_r, ds_r};
        default: rresp_nxt = HSP_RESP_SLVERR;
      endcase
    end
    if (r_r && i_rready) begin
      r_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl_r <= HSP_CTRL_RST; // [R11]
      dir_r <= HSP_DIR_RST;
      dout_r <= HSP_DOUT_RST;
      sw_req_r <= 1'b0;
      sw_tr_r <= 2'b00;
      pin_r <= 4'h0;
      oe_r <= 4'h0;
      in_r <= 4'h0;
      ds_r <= 1'b0;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      ack_r <= 1'b0;
      aw_r <= 1'b0;
      w_r <= 1'b0;
      awa_r <= 8'h00;
      wd_r <= 32'h0000_0000;
      b_r <= 1'b0;
      bresp_r <= HSP_RESP_OKAY;
      ar_r <= 1'b0;
      aw_rdy_r <= 1'b0;
      w_rdy_r <= 1'b0;
      r_r <= 1'b0;
      rd_data_r <= 32'h0000_0000;
      rresp_r <= HSP_RESP_OKAY;
    end else begin
      ctrl_r <= ctrl_nxt;
      dir_r <= dir_nxt;
      dout_r <= dout_nxt;
      sw_req_r <= sw_req_nxt;
      sw_tr_r <= sw_tr_nxt;
      pin_r <= pin_nxt;
      oe_r <= oe_nxt;
      in_r <= in_nxt;
      ds_r <= ds_nxt;
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      ack_r <= ack_nxt;
      aw_r <= aw_nxt;
      w_r <= w_nxt;
      awa_r <= awa_nxt;
      wd_r <= wd_nxt;
      b_r <= b_nxt;
      bresp_r <= bresp_nxt;
      ar_r <= ar_nxt;
      aw_rdy_r <= aw_rdy_nxt;
      w_rdy_r <= w_rdy_nxt;
      r_r <= r_nxt;
      rd_data_r <= rd_data_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // Ready pulses are registered; capture flags hold off a second beat
  assign o_awready = aw_rdy_r;
  assign o_wready = w_rdy_r;
  assign o_arready = ar_r;
  assign o_bvalid = b_r;
  assign o_bresp = bresp_r;
  assign o_rvalid = r_r;
  assign o_rdata = rd_data_r;
  assign o_rresp = rresp_r;
  assign o_pin = pin_r;
  assign o_pin_oe = oe_r;
  assign o_data_strobe = ds_r;
  assign o_write_strobe = wr_r;
  assign o_read_strobe = rd_r;
  assign o_host_ack = ack_r;
endmodule

/* verilog/hsp_pkg.sv */
// Package with register map and field constants for the host strobe pins
package hsp_pkg;
  // Register byte offsets
  localparam logic [7:0] HSP_CTRL_OFS = 8'h00;
  localparam logic [7:0] HSP_DIR_OFS = 8'h04;
  localparam logic [7:0] HSP_DOUT_OFS = 8'h08;
  localparam logic [7:0] HSP_PIN_OFS = 8'h0c;
  localparam logic [7:0] HSP_REQ_OFS = 8'h10;
  localparam logic [7:0] HSP_STAT_OFS = 8'h14;
  // Control register field positions
  localparam int HSP_GPIO_BIT = 0;
  localparam int HSP_DSTROBE_BIT = 1;
  localparam int HSP_DREQ_BIT = 2;
  localparam int HSP_OD_BIT = 3;
  localparam int HSP_POL_DS_BIT = 4;
  localparam int HSP_POL_WR_BIT = 5;
  localparam int HSP_POL_RD_BIT = 6;
  localparam int HSP_POL_REQ_BIT = 7;
  localparam int HSP_POL_TRQ_BIT = 8;
  localparam int HSP_POL_RRQ_BIT = 9;
  localparam int HSP_POL_ACK_BIT = 10;
  localparam int HSP_CTRL_W = 11;
  // Reset values: host function, single styles, driven, all active low
  localparam logic [10:0] HSP_CTRL_RST = 11'h000;
  localparam logic [3:0] HSP_DIR_RST = 4'h0;
  localparam logic [3:0] HSP_DOUT_RST = 4'h0;
  localparam logic [1:0] HSP_RESP_OKAY = 2'b00;
  localparam logic [1:0] HSP_RESP_SLVERR = 2'b10;
endpackage
